// file: rtl/pec_engine.v
// printer engine control: cassette size, scanner motor, scan warm-up and fuser lamp
`timescale 1ns/10ps
`include "pec_regs.vh"

module pec_engine
#(
  parameter CLK_HZ      = `PEC_CLK_HZ,
  parameter SAMPLE_MS   = `PEC_SAMPLE_MS,
  parameter STOP_S      = `PEC_STOP_S,
  parameter SAMPLE_CYC  = CLK_HZ / 1000 * SAMPLE_MS,
  parameter STOP_CYC    = CLK_HZ * STOP_S,
  parameter SCAN_HZ_MIL = `PEC_SCAN_HZ_MILLI
)
(
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        size_switch_first,
  input  wire        size_switch_second,
  input  wire        size_switch_third,
  input  wire        size_switch_fourth,
  input  wire        start_of_scan_pulse,
  input  wire [9:0]  roll_temp,
  input  wire        main_motor_request,
  output reg         scanner_motor_on,
  output reg         scanner_clk,
  output reg         scanner_speed_fault,
  output reg         fuser_lamp_on,
  output reg         main_motor_on,
  output reg         fuser_abnormal
);

  // ************************************************************
  // derived constants
  // ************************************************************
  // half period of the speed reference, in clocks (rounded down)
  localparam [63:0] HALF_W     = (CLK_HZ / 2) * 64'd1000 / SCAN_HZ_MIL;
  localparam [31:0] HALF_CYC   = HALF_W[31:0];
  localparam [31:0] NOM_CYC    = HALF_CYC * 2;
  // slower motor means longer interval: ref = nominal * 100 / pct
  localparam [31:0] READY_CYC  = NOM_CYC * 100 / `PEC_READY_PCT;
  localparam [31:0] FAIL_CYC   = NOM_CYC * 100 / `PEC_FAIL_PCT;
  localparam [31:0] SAMPLE_C32 = SAMPLE_CYC;
  localparam [31:0] STOP_C32   = STOP_CYC;

  // scan states, one-hot
  localparam [3:0] SC_OFF  = 4'h1;
  localparam [3:0] SC_WARM = 4'h2;
  localparam [3:0] SC_RUN  = 4'h4;
  localparam [3:0] SC_TAIL = 4'h8;

  // ************************************************************
  // size decode function
  // ************************************************************
  function [3:0] size_to_paper;
    input [3:0] code;
    begin
      case (code)
        4'h0:    size_to_paper = `PEC_PAPER_NONE;
        4'h1:    size_to_paper = `PEC_PAPER_EXEC;
        4'h3:    size_to_paper = `PEC_PAPER_B5;
        4'h5:    size_to_paper = `PEC_PAPER_A5;
        4'h7:    size_to_paper = `PEC_PAPER_LGL14;
        4'h9:    size_to_paper = `PEC_PAPER_LETTER;
        4'hd:    size_to_paper = `PEC_PAPER_A4;
        4'hf:    size_to_paper = `PEC_PAPER_LGL13;
        default: size_to_paper = `PEC_PAPER_BAD;
      endcase
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg  [1:0]  mode_reg;
  reg         print_reg;
  reg         fwarm_req_reg;
  reg  [9:0]  temp_stby_reg;
  reg  [9:0]  temp_run_reg;
  reg  [3:0]  size_reg;
  reg  [3:0]  scan_state_reg;
  reg  [31:0] tail_cnt_reg;
  reg  [31:0] samp_cnt_reg;
  reg  [31:0] intv_cnt_reg;
  reg  [31:0] last_intv_reg;
  reg         intv_valid_reg;
  reg  [1:0]  good_cnt_reg;
  reg         sos_d_reg;
  reg  [31:0] half_cnt_reg;
  reg         fwarm_reg;
  reg         scan_ready_reg;
  wire        sos_rise;
  wire [9:0]  target;
  wire [31:0] status_word;
  wire        bus_hit;
  wire        wr_take;

  assign sos_rise = start_of_scan_pulse & ~sos_d_reg;

  // ************************************************************
  // avalon slave: one wait cycle, then answer
  // ************************************************************
  // waitrequest drops for one cycle after a request is seen
  assign bus_hit = (avs_read | avs_write) & avs_waitrequest;
  // writes land only at the completing edge, so a master that gives up early changes nothing
  assign wr_take = avs_write & ~avs_waitrequest;
  assign status_word = {17'h0, main_motor_on, fuser_abnormal, fwarm_reg, fuser_lamp_on,
                        scanner_speed_fault, scan_ready_reg, scanner_motor_on,
                        size_to_paper(size_reg), size_reg};

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      mode_reg        <= `PEC_MODE_STANDBY;
      print_reg       <= 1'b0;
      fwarm_req_reg   <= 1'b0;
      temp_stby_reg   <= `PEC_TEMP_STBY_RST;
      temp_run_reg    <= `PEC_TEMP_RUN_RST;
    end
    else
    begin
      avs_waitrequest <= ~bus_hit;
      // warm-up request is a self-clearing start strobe
      fwarm_req_reg   <= 1'b0;
      if (bus_hit && avs_read)
      begin
        case (avs_address)
          `PEC_OFF_CTRL:      avs_readdata <= {28'h0, fwarm_reg, print_reg, mode_reg};
          `PEC_OFF_STATUS:    avs_readdata <= status_word;
          `PEC_OFF_TEMP_STBY: avs_readdata <= {22'h0, temp_stby_reg};
          `PEC_OFF_TEMP_RUN:  avs_readdata <= {22'h0, temp_run_reg};
          default:            avs_readdata <= 32'h0;   // unmapped reads zero
        endcase
      end
      if (wr_take && avs_byteenable[0])
      begin
        case (avs_address)
          `PEC_OFF_CTRL:
          begin
            mode_reg      <= avs_writedata[`PEC_CTRL_MODE_HI:`PEC_CTRL_MODE_LO];
            print_reg     <= avs_writedata[`PEC_CTRL_PRINT];
            fwarm_req_reg <= avs_writedata[`PEC_CTRL_FWARM];
          end
          `PEC_OFF_TEMP_STBY: temp_stby_reg[7:0] <= avs_writedata[7:0];
          `PEC_OFF_TEMP_RUN:  temp_run_reg[7:0]  <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (wr_take && avs_byteenable[1])
      begin
        case (avs_address)
          `PEC_OFF_TEMP_STBY: temp_stby_reg[9:8] <= avs_writedata[9:8];
          `PEC_OFF_TEMP_RUN:  temp_run_reg[9:8]  <= avs_writedata[9:8];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // cassette size switches
  // ************************************************************
  // switch one lands in the msb so the code reads as printed
  always @(posedge sys_clk)
  begin
    if (!resetn)
      size_reg <= 4'h0;
    else
      size_reg <= {size_switch_first, size_switch_second,
                   size_switch_third, size_switch_fourth};
  end

  // ************************************************************
  // scanner speed reference clock
  // ************************************************************
  // divider held cleared while the motor is off; drift of the rounding is below one clock per half period
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      half_cnt_reg <= 32'h0;
      scanner_clk  <= 1'b0;
    end
    else if (!scanner_motor_on)
    begin
      half_cnt_reg <= 32'h0;
      scanner_clk  <= 1'b0;
    end
    else if (half_cnt_reg == HALF_CYC - 32'h1)
    begin
      half_cnt_reg <= 32'h0;
      scanner_clk  <= ~scanner_clk;
    end
    else
      half_cnt_reg <= half_cnt_reg + 32'h1;
  end

  // ************************************************************
  // scanner motor state machine and warm-up sampling
  // ************************************************************
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      scan_state_reg      <= SC_OFF;
      scanner_motor_on    <= 1'b0;
      scanner_speed_fault <= 1'b0;
      scan_ready_reg      <= 1'b0;
      tail_cnt_reg        <= 32'h0;
      samp_cnt_reg        <= 32'h0;
      intv_cnt_reg        <= 32'h0;
      last_intv_reg       <= 32'h0;
      intv_valid_reg      <= 1'b0;
      good_cnt_reg        <= 2'h0;
      sos_d_reg           <= 1'b0;
    end
    else
    begin
      sos_d_reg <= start_of_scan_pulse;
      // interval between pulses, saturating at the fail limit
      if (sos_rise)
      begin
        last_intv_reg  <= intv_cnt_reg;
        intv_valid_reg <= 1'b1;
        // the edge cycle itself is the first clock of the next interval
        intv_cnt_reg   <= 32'h1;
      end
      else if (intv_cnt_reg != FAIL_CYC)
        intv_cnt_reg <= intv_cnt_reg + 32'h1;
      if (mode_reg != `PEC_MODE_PRINT)
      begin
        // leaving print mode drops the motor at once
        scan_state_reg   <= SC_OFF;
        scanner_motor_on <= 1'b0;
        scan_ready_reg   <= 1'b0;
      end
      else
      begin
        case (scan_state_reg)
          SC_OFF:
          begin
            if (print_reg && !scanner_speed_fault)
            begin
              scan_state_reg   <= SC_WARM;
              scanner_motor_on <= 1'b1;
              samp_cnt_reg     <= 32'h0;
              intv_valid_reg   <= 1'b0;
              good_cnt_reg     <= 2'h0;
            end
          end
          SC_WARM:
          begin
            if (samp_cnt_reg == SAMPLE_C32 - 32'h1)
            begin
              samp_cnt_reg   <= 32'h0;
              // a pulse in the sampling cycle still counts for the next period
              intv_valid_reg <= sos_rise;
              if (!intv_valid_reg || last_intv_reg >= FAIL_CYC || intv_cnt_reg >= FAIL_CYC)
              begin
                // no pulse in the period counts as below fail speed
                scanner_speed_fault <= 1'b1;
                scanner_motor_on    <= 1'b0;
                scan_state_reg      <= SC_OFF;
              end
              else if (last_intv_reg < READY_CYC)
              begin
                if (good_cnt_reg == `PEC_GOOD_RUN - 2'h1)
                begin
                  scan_state_reg <= SC_RUN;
                  scan_ready_reg <= 1'b1;
                end
                good_cnt_reg <= good_cnt_reg + 2'h1;
              end
              else
                good_cnt_reg <= 2'h0;
            end
            else
              samp_cnt_reg <= samp_cnt_reg + 32'h1;
          end
          SC_RUN:
          begin
            if (!print_reg)
            begin
              scan_state_reg <= SC_TAIL;
              tail_cnt_reg   <= 32'h0;
            end
          end
          SC_TAIL:
          begin
            if (print_reg)
              scan_state_reg <= SC_RUN;
            else if (tail_cnt_reg == STOP_C32 - 32'h1)
            begin
              scan_state_reg   <= SC_OFF;
              scanner_motor_on <= 1'b0;
              scan_ready_reg   <= 1'b0;
            end
            else
              tail_cnt_reg <= tail_cnt_reg + 32'h1;
          end
          default:
          begin
            scan_state_reg   <= SC_OFF;
            scanner_motor_on <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // fuser control
  // ************************************************************
  // target is standby during warm-up or with the main motor at rest
  assign target = (fwarm_reg || !main_motor_on) ? temp_stby_reg : temp_run_reg;

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      fwarm_reg      <= 1'b0;
      fuser_lamp_on  <= 1'b0;
      fuser_abnormal <= 1'b0;
      main_motor_on  <= 1'b0;
    end
    else
    begin
      if (roll_temp >= `PEC_TEMP_HIGH || roll_temp <= `PEC_TEMP_LOW)
        fuser_abnormal <= 1'b1;
      main_motor_on <= fwarm_reg | main_motor_request;
      if (fwarm_req_reg && !fwarm_reg)
        fwarm_reg <= 1'b1;
      else if (fwarm_reg && roll_temp >= temp_stby_reg)
        fwarm_reg <= 1'b0;
      // sticky abnormal flag overrides all lamp demand
      if (fuser_abnormal)
        fuser_lamp_on <= 1'b0;
      else if (fwarm_req_reg && !fwarm_reg)
        fuser_lamp_on <= 1'b1;
      else
        fuser_lamp_on <= (roll_temp < target);
    end
  end

endmodule // pec_engine

// file: rtl/pec_regs.vh
// register map, field positions and timing constants of the printer engine control block
`ifndef PEC_REGS_VH
`define PEC_REGS_VH
// ************************************************************
// register offsets (byte addresses, word aligned)
// ************************************************************
`define PEC_ADDR_W         4
`define PEC_OFF_CTRL       4'h0
`define PEC_OFF_STATUS     4'h4
`define PEC_OFF_TEMP_STBY  4'h8
`define PEC_OFF_TEMP_RUN   4'hc
// ************************************************************
// control register fields
// ************************************************************
`define PEC_CTRL_MODE_LO   0
`define PEC_CTRL_MODE_HI   1
`define PEC_CTRL_PRINT     2
`define PEC_CTRL_FWARM     3
`define PEC_MODE_STANDBY   2'h0
`define PEC_MODE_PRINT     2'h1
`define PEC_MODE_SAVE      2'h2
// ************************************************************
// status register fields
// ************************************************************
`define PEC_ST_SIZE_LO     0
`define PEC_ST_SIZE_HI     3
`define PEC_ST_PAPER_LO    4
`define PEC_ST_PAPER_HI    7
`define PEC_ST_SCAN_ON     8
`define PEC_ST_SCAN_RDY    9
`define PEC_ST_SCAN_FLT    10
`define PEC_ST_LAMP        11
`define PEC_ST_FWARM       12
`define PEC_ST_FUSE_ABN    13
`define PEC_ST_MAIN        14
// ************************************************************
// paper size codes reported by the decoder
// ************************************************************
`define PEC_PAPER_NONE     4'h0
`define PEC_PAPER_EXEC     4'h1
`define PEC_PAPER_B5       4'h2
`define PEC_PAPER_A5       4'h3
`define PEC_PAPER_LGL14    4'h4
`define PEC_PAPER_LETTER   4'h5
`define PEC_PAPER_A4       4'h6
`define PEC_PAPER_LGL13    4'h7
`define PEC_PAPER_BAD      4'hf
// ************************************************************
// temperatures in degrees c, 10-bit
// ************************************************************
`define PEC_TEMP_W         10
`define PEC_TEMP_STBY_RST  10'h0b4
`define PEC_TEMP_RUN_RST   10'h0b9
`define PEC_TEMP_HIGH      10'h0fa
`define PEC_TEMP_LOW       10'h082
// ************************************************************
// timing
// ************************************************************
`define PEC_CLK_HZ         125000000
`define PEC_SAMPLE_MS      100
`define PEC_STOP_S         10
`define PEC_SCAN_HZ_MILLI  2049449
`define PEC_READY_PCT      98
`define PEC_FAIL_PCT       90
`define PEC_GOOD_RUN       2'h3
`endif

// file: testbench/pec_engine_chk.sv
// port-level assertions for the printer engine control block
`timescale 1ns/10ps
module pec_engine_chk
#(
  parameter SAMPLE_CYC = 2000
)
(
  input wire       sys_clk,
  input wire       resetn,
  input wire       avs_read,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire       start_of_scan_pulse,
  input wire [9:0] roll_temp,
  input wire       main_motor_request,
  input wire       scanner_motor_on,
  input wire       scanner_clk,
  input wire       scanner_speed_fault,
  input wire       fuser_lamp_on,
  input wire       main_motor_on,
  input wire       fuser_abnormal
);
  // a free-running sampler may need a second period to see a lost pulse
  localparam int GAP = 2 * SAMPLE_CYC + 4;
  reg [31:0] gap_reg;
  reg        pulse_reg;
  // cycles since the last scan pulse while the motor turns
  always @(posedge sys_clk)
  begin
    pulse_reg <= start_of_scan_pulse;
    if (!resetn || !scanner_motor_on || (start_of_scan_pulse && !pulse_reg))
      gap_reg <= 32'h0;
    else
      gap_reg <= gap_reg + 32'h1;
  end
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_scan_idle: assert property (!scanner_motor_on && !$past(scanner_motor_on) |-> !scanner_clk)
    else $error("speed clock runs with motor off");
  a_fault_stop: assert property (scanner_speed_fault |=> !scanner_motor_on)
    else $error("scanner motor runs with a speed fault");
  a_fault_hold: assert property (scanner_speed_fault |=> scanner_speed_fault)
    else $error("speed fault cleared without reset");
  a_pulse_gap: assert property (gap_reg > GAP |-> scanner_speed_fault)
    else $error("missing scan pulses not flagged");
  a_abn_limit: assert property (roll_temp >= 10'h0fa || roll_temp <= 10'h082 |-> ##[1:2] fuser_abnormal)
    else $error("abnormal temperature not flagged");
  a_abn_lamp: assert property (fuser_abnormal |=> !fuser_lamp_on)
    else $error("lamp on with abnormal temperature");
  a_abn_hold: assert property (fuser_abnormal |=> fuser_abnormal)
    else $error("abnormal flag cleared without reset");
  a_main_req: assert property (main_motor_request |=> main_motor_on)
    else $error("main motor ignores request");
endmodule // pec_engine_chk

// file: testbench/pec_engine_tb.sv
// self-checking bench for the printer engine control block
`timescale 1ns/10ps
`include "pec_regs.vh"
module pec_engine_tb;
  // slow clock figure keeps scan intervals below one sampling period
  localparam CLK_HZ = 1000000;
  localparam SAMPLE = 2000;
  localparam STOP   = 500;
  localparam NOM    = 2 * ((CLK_HZ / 2) * 1000 / `PEC_SCAN_HZ_MILLI);
  localparam READY  = NOM * 100 / `PEC_READY_PCT;
  localparam FAIL   = NOM * 100 / `PEC_FAIL_PCT;
  localparam longint SCK = SAMPLE * 64'd1 * `PEC_SCAN_HZ_MILLI / (CLK_HZ * 64'd1000);
  localparam [3:0] CT = `PEC_OFF_CTRL;
  logic        sys_clk, resetn, avs_read, avs_write, main_motor_request, p;
  logic [3:0]  avs_address, sw;
  logic [31:0] avs_writedata, d;
  logic [9:0]  roll_temp;
  logic [15:0] scan_period;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, start_of_scan_pulse, scanner_motor_on, scanner_clk;
  wire         scanner_speed_fault, fuser_lamp_on, main_motor_on, fuser_abnormal;
  int          n_fail, n_tests, i, k;
  logic [3:0]  cod [9];
  logic [3:0]  pap [9];
  pec_engine #(.CLK_HZ(CLK_HZ), .SAMPLE_CYC(SAMPLE), .STOP_CYC(STOP)) i_pec_engine
  (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .size_switch_first(sw[3]), .size_switch_second(sw[2]), .size_switch_third(sw[1]),
    .size_switch_fourth(sw[0]), .start_of_scan_pulse(start_of_scan_pulse), .roll_temp(roll_temp),
    .main_motor_request(main_motor_request), .scanner_motor_on(scanner_motor_on),
    .scanner_clk(scanner_clk), .scanner_speed_fault(scanner_speed_fault),
    .fuser_lamp_on(fuser_lamp_on), .main_motor_on(main_motor_on), .fuser_abnormal(fuser_abnormal)
  );
  pec_far_model i_pec_far_model
  (
    .sys_clk(sys_clk), .scanner_motor_on(scanner_motor_on), .scan_period(scan_period),
    .start_of_scan_pulse(start_of_scan_pulse)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // bus, compare and run-control tasks
  // ************************************************************
  task close_out;
    begin
      $display("counts: %0d compares, %0d mismatches", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task stop_run(input string m);
    begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
      close_out();
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_tests++;
      if (g !== e)
      begin
        n_fail++;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    begin
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0)
        stop_run("bus timeout");
    end
  endtask
  task st_bit(input int b, input logic v);
    begin
      repeat (2) @(posedge sys_clk);
      bus(1'b0, `PEC_OFF_STATUS, 32'h0, d);
      chk({31'h0, d[b]}, {31'h0, v});
    end
  endtask
  // status polled under a bound of n reads
  task wait_st(input int b, input logic v, input int n);
    int j;
    begin
      for (j = 0; j < n; j++)
      begin
        bus(1'b0, `PEC_OFF_STATUS, 32'h0, d);
        if (d[b] === v)
          break;
      end
      chk({31'h0, d[b]}, {31'h0, v});
      if (d[b] !== v)
        stop_run("status wait timeout");
    end
  endtask
  task rst;
    begin
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {resetn, avs_read, avs_write, main_motor_request} = 4'h0;
    {avs_address, sw, avs_writedata, scan_period} = 56'h0;
    roll_temp = 10'h0aa;
    n_fail = 0;
    n_tests = 0;
    cod = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hd, 4'hf, 4'h2};
    pap = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
    rst();
    bus(1'b0, `PEC_OFF_TEMP_STBY, 32'h0, d);
    chk(d, 32'h0b4);
    bus(1'b0, `PEC_OFF_TEMP_RUN, 32'h0, d);
    chk(d, 32'h0b9);
    bus(1'b1, 4'h2, 32'hffff_ffff, d);
    bus(1'b0, 4'h2, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b1, `PEC_OFF_STATUS, 32'h0000_ffff, d);
    st_bit(`PEC_ST_SCAN_ON, 1'b0);
    $display("test registers done");
    // every cassette code, plus one that no cassette gives
    for (i = 0; i < 9; i++)
    begin
      sw <= cod[i];
      st_bit(`PEC_ST_SCAN_ON, 1'b0);
      chk({24'h0, d[7:0]}, {24'h0, pap[i], cod[i]});
    end
    $display("test size done");
    bus(1'b1, CT, 32'h4, d);
    repeat (20) @(posedge sys_clk);
    st_bit(`PEC_ST_SCAN_ON, 1'b0);
    bus(1'b1, CT, 32'h6, d);
    repeat (20) @(posedge sys_clk);
    st_bit(`PEC_ST_SCAN_ON, 1'b0);
    $display("test idle modes done");
    scan_period <= 16'(READY - 40);
    bus(1'b1, CT, 32'h5, d);
    st_bit(`PEC_ST_SCAN_ON, 1'b1);
    repeat (2 * SAMPLE - 100) @(posedge sys_clk);
    st_bit(`PEC_ST_SCAN_RDY, 1'b0);
    wait_st(`PEC_ST_SCAN_RDY, 1'b1, 3 * SAMPLE);
    k = 0;
    p = 1'b0;
    repeat (SAMPLE)
    begin
      @(posedge sys_clk);
      k += int'(scanner_clk && !p);
      p = scanner_clk;
    end
    chk(32'(k >= SCK && k <= SCK + 1), 32'h1);
    bus(1'b1, CT, 32'h1, d);
    repeat (STOP - 100) @(posedge sys_clk);
    st_bit(`PEC_ST_SCAN_ON, 1'b1);
    wait_st(`PEC_ST_SCAN_ON, 1'b0, 100);
    $display("test scan warm-up done");
    // between ready and fail: neither ready nor fault
    rst();
    scan_period <= 16'((READY + FAIL) / 2);
    bus(1'b1, CT, 32'h5, d);
    repeat (5 * SAMPLE) @(posedge sys_clk);
    st_bit(`PEC_ST_SCAN_RDY, 1'b0);
    st_bit(`PEC_ST_SCAN_FLT, 1'b0);
    rst();
    scan_period <= 16'(FAIL + 60);
    bus(1'b1, CT, 32'h5, d);
    wait_st(`PEC_ST_SCAN_FLT, 1'b1, 2 * SAMPLE);
    rst();
    scan_period <= 16'h0;
    bus(1'b1, CT, 32'h5, d);
    wait_st(`PEC_ST_SCAN_FLT, 1'b1, 2 * SAMPLE);
    st_bit(`PEC_ST_SCAN_ON, 1'b0);
    $display("test scan fault done");
    rst();
    roll_temp <= 10'h096;
    bus(1'b1, CT, 32'h8, d);
    st_bit(`PEC_ST_LAMP, 1'b1);
    st_bit(`PEC_ST_MAIN, 1'b1);
    roll_temp <= 10'h0b4;
    wait_st(`PEC_ST_FWARM, 1'b0, 20);
    st_bit(`PEC_ST_LAMP, 1'b0);
    roll_temp <= 10'h0af;
    st_bit(`PEC_ST_LAMP, 1'b1);
    main_motor_request <= 1'b1;
    roll_temp <= 10'h0b7;
    st_bit(`PEC_ST_LAMP, 1'b1);
    roll_temp <= 10'h0ba;
    st_bit(`PEC_ST_LAMP, 1'b0);
    bus(1'b1, `PEC_OFF_TEMP_STBY, 32'h0be, d);
    main_motor_request <= 1'b0;
    st_bit(`PEC_ST_LAMP, 1'b1);
    roll_temp <= 10'h0f9;
    st_bit(`PEC_ST_FUSE_ABN, 1'b0);
    roll_temp <= 10'h0fa;
    st_bit(`PEC_ST_FUSE_ABN, 1'b1);
    roll_temp <= 10'h0aa;
    st_bit(`PEC_ST_LAMP, 1'b0);
    rst();
    roll_temp <= 10'h083;
    st_bit(`PEC_ST_FUSE_ABN, 1'b0);
    roll_temp <= 10'h082;
    st_bit(`PEC_ST_FUSE_ABN, 1'b1);
    $display("test fuser done");
    close_out();
  end
endmodule // pec_engine_tb

bind pec_engine pec_engine_chk #(.SAMPLE_CYC(SAMPLE_CYC)) i_pec_engine_chk
(
  .sys_clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .start_of_scan_pulse, .roll_temp,
  .main_motor_request, .scanner_motor_on, .scanner_clk, .scanner_speed_fault, .fuser_lamp_on,
  .main_motor_on, .fuser_abnormal
);

// file: testbench/pec_far_model.sv
// scan sensor model: beam pulses at a set period while the motor turns
`timescale 1ns/10ps
module pec_far_model
(
  input  wire        sys_clk,
  input  wire        scanner_motor_on,
  input  wire [15:0] scan_period,
  output reg         start_of_scan_pulse
);
  reg [15:0] cnt_reg;
  initial
  begin
    cnt_reg = 16'h0;
    start_of_scan_pulse = 1'b0;
  end
  // period zero models an overspeeding motor whose beam misses the sensor
  always @(posedge sys_clk)
  begin
    if (!scanner_motor_on || scan_period == 16'h0)
      cnt_reg <= 16'h0;
    else if (cnt_reg >= scan_period - 16'h1)
      cnt_reg <= 16'h0;
    else
      cnt_reg <= cnt_reg + 16'h1;
    start_of_scan_pulse <= scanner_motor_on && scan_period != 16'h0 && cnt_reg < 16'h4;
  end
endmodule // pec_far_model
